// ---- core/evp_cfg.svh ----
`ifndef EVP_CFG_SVH
`define EVP_CFG_SVH
`define EVP_AUTO_RATE_SPS   16'h0271
`define EVP_MICRO_FAST      8'h08
`define EVP_MICRO_SLOW      8'h10
`define EVP_DUTY_FULL_PCT   8'h64
`define EVP_DUTY_PERIOD_MS  8'h64
`define EVP_CLK_HZ          32'h0131_2D00
`define EVP_CYC_PER_MS      (`EVP_CLK_HZ / 32'h0000_03E8)
`define EVP_RESYNC_PCT      8'h0A
`define EVP_DECEL_STEPS     16'h0020
`define EVP_CFG_ERR_NOMAX   8'h17
`endif

// ---- core/evp_pkg.sv ----
package evp_pkg;
	typedef enum logic [2:0] {
		EVP_ST_POWERUP  = 3'b000,
		EVP_ST_RESYNC   = 3'b001,
		EVP_ST_TO_STBY  = 3'b010,
		EVP_ST_STBY_OFF = 3'b011,
		EVP_ST_ENABLED  = 3'b100,
		EVP_ST_FORCED   = 3'b101
	} evp_state_t;
	typedef enum logic [1:0] {
		EVP_MODE_NORMAL = 2'b00,
		EVP_MODE_MANUAL = 2'b01,
		EVP_MODE_DEBUG  = 2'b10
	} evp_mode_t;
	typedef struct packed {
		logic [15:0] min_steps;
		logic [15:0] max_steps;
		logic [15:0] over_steps;
		logic [15:0] rate_sps;
		logic [15:0] op_ma;
		logic [15:0] hold_ma;
		logic [7:0]  step_mode;
	} evp_valve_t;
endpackage

// ---- core/evp_valve_rom.sv ----
`timescale 1ns/10ps
// stored per-model defaults; read data registered
module evp_valve_rom (
	input  wire logic              mclk,
	input  wire logic [7:0]        valve_model_select,
	output evp_pkg::evp_valve_t    rd_q
);
	evp_pkg::evp_valve_t rd_d;
	always_comb begin
		rd_d = '0;
		case (valve_model_select)
			8'h14: rd_d = '{16'h0000, 16'h019F, 16'h0203, 16'h0023, 16'h00C8, 16'h0000, 8'h00};
			8'h15: rd_d = '{16'h0000, 16'h00C3, 16'h00FF, 16'h0019, 16'h00C8, 16'h0032, 8'h00};
			8'h16: rd_d = '{16'h0000, 16'h03D9, 16'h046F, 16'h0046, 16'h0230, 16'h0032, 8'h00};
			8'h1E: rd_d = '{16'h0010, 16'h00FA, 16'h015E, 16'h002D, 16'h0082, 16'h0000, 8'h01};
			8'h1F: rd_d = '{16'h0000, 16'h02EE, 16'h03E8, 16'h01F4, 16'h01F4, 16'h0064, 8'h00};
			8'h20: rd_d = '{16'h0000, 16'h0640, 16'h07D0, 16'h01F4, 16'h02EE, 16'h00FA, 8'h00};
			8'h21: rd_d = '{16'h0000, 16'h0A28, 16'h0CB2, 16'h01F4, 16'h0320, 16'h01F4, 8'h00};
			8'h28: rd_d = '{16'h001E, 16'h0258, 16'h0274, 16'h00F0, 16'h0320, 16'h00A0, 8'h00};
			8'h29: rd_d = '{16'h0000, 16'h0A41, 16'h0C4E, 16'h012C, 16'h0064, 16'h004B, 8'h00};
			8'h2A: rd_d = '{16'h0000, 16'h0DCA, 16'h109A, 16'h012C, 16'h0064, 16'h004B, 8'h00};
			8'h2B: rd_d = '{16'h0000, 16'h0EE2, 16'h11C6, 16'h012C, 16'h0064, 16'h004B, 8'h00};
			8'h2C: rd_d = '{16'h0000, 16'h00F0, 16'h0104, 16'h0019, 16'h0104, 16'h0000, 8'h01};
			8'h32: rd_d = '{16'h0000, 16'h0A28, 16'h0BB8, 16'h012C, 16'h008C, 16'h0000, 8'h00};
			8'h33: rd_d = '{16'h0000, 16'h0DAC, 16'h1130, 16'h012C, 16'h008C, 16'h0000, 8'h00};
			8'h34: rd_d = '{16'h0000, 16'h0ED8, 16'h1130, 16'h012C, 16'h008C, 16'h0000, 8'h00};
			8'h37: rd_d = '{16'h0032, 16'h01E0, 16'h01F4, 16'h0032, 16'h01C2, 16'h0064, 8'h00};
			default: rd_d = '0;
		endcase
	end
	always_ff @(posedge mclk) begin
		rd_q <= rd_d;
	end
endmodule

// ---- core/evp_positioner.sv ----
`timescale 1ns/10ps
`include "evp_cfg.svh"
// Behaviour
// - nonzero model loads all valve parameters from stored defaults.
// - model zero uses individually configured generic parameters.
// - driving mode select zero picks microstep mode automatically.
// - auto mode: 8 microsteps above 625 steps/s, else 16.
// - operating current share bounded by duty limit, holding current otherwise.
// - 70 percent gives 70 ms operating, 30 ms holding; scales.
// - duty limit 100 percent disables limiting entirely.
// - forced movements ignore duty limiting while forced_move is held.
// - power-on resync closes by overdrive step count.
// - normal resync goes to step 0 then 10 percent max further.
// - resync performed automatically at every power-on.
// - 0 percent maps to minimum steps, 100 percent to maximum scaled by opening limit.
// - standalone mode: rising digital input two requests resync if configured.
// - network mode: rising resync request flag requests resync.
// - internal algorithm request or hours reaching interval requests resync.
// - pending resync runs only in stand-by; held while enabled.
// - registered resync request cannot be cancelled.
// - never step faster than the valve stepping rate.
// - resync moves at full speed, half speed for the last 31 steps.
// - debug mode steps at the debug step rate.
// - manual and other positioning step at maximum speed.
// - requested percentage scaled by opening limit before step conversion.
// - percent reports relative to opening limit; step position is physical.
// - effective maximum steps zero flags configuration error 23.
// - on disable move to stand-by position, then stand-by off.
module evp_positioner (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [7:0]  valve_model_select,
	input  wire logic [15:0] gen_min_steps,
	input  wire logic [15:0] gen_max_steps,
	input  wire logic [15:0] gen_over_steps,
	input  wire logic [15:0] gen_rate_sps,
	input  wire logic [15:0] gen_op_ma,
	input  wire logic [15:0] gen_hold_ma,
	input  wire logic [7:0]  gen_step_mode,
	input  wire logic [7:0]  driving_mode_select,
	input  wire logic [7:0]  valve_duty_limit,
	input  wire logic        enable_source_mode,
	input  wire logic        di2_is_resync,
	input  wire logic        digital_input_two,
	input  wire logic        resync_request_flag,
	input  wire logic        algo_resync_req,
	input  wire logic [31:0] operating_hours_count,
	input  wire logic [31:0] resync_interval_hours,
	input  wire logic        valve_enable,
	input  wire logic        forced_move,
	input  wire logic [1:0]  op_mode,
	input  wire logic [15:0] debug_step_rate,
	input  wire logic [7:0]  opening_limit_pct,
	input  wire logic [7:0]  standby_position,
	input  wire logic [7:0]  target_pct,
	output logic             step_pulse,
	output logic             step_dir_open,
	output logic             use_op_current,
	output logic [15:0]      coil_current_ma,
	output logic [7:0]       microsteps_q,
	output logic signed [17:0] position_q,
	output logic [7:0]       position_pct_q,
	output logic [7:0]       setpoint_pct_q,
	output logic             resync_pending_q,
	output logic             resync_busy,
	output logic [2:0]       state_code,
	output logic             cfg_error,
	output logic [7:0]       cfg_error_code
);
	evp_pkg::evp_valve_t rom_q;
	evp_pkg::evp_valve_t vp;
	evp_valve_rom u_rom (
		.mclk               (mclk),
		.valve_model_select (valve_model_select),
		.rd_q               (rom_q)
	);

	always_comb begin
		if (valve_model_select != 8'h00) begin
			vp = rom_q;
		end else begin
			vp = '{gen_min_steps, gen_max_steps, gen_over_steps, gen_rate_sps,
				gen_op_ma, gen_hold_ma, gen_step_mode};
		end
	end

	assign cfg_error      = (vp.max_steps == 16'h0000);
	assign cfg_error_code = cfg_error ? `EVP_CFG_ERR_NOMAX : 8'h00;

	// pin inputs synchronised before edge detection
	logic [1:0] di2_s_q, di2_s_d, rr_s_q, rr_s_d;
	logic       di2_old_q, rr_old_q, hrs_old_q;
	logic       hrs_hit;
	assign di2_s_d = {di2_s_q[0], digital_input_two};
	assign rr_s_d  = {rr_s_q[0], resync_request_flag};
	assign hrs_hit = (resync_interval_hours != 32'h0000_0000) &&
		(operating_hours_count >= resync_interval_hours);

	evp_pkg::evp_state_t st_q, st_d;
	logic              pend_d, req_new;
	logic [16:0]       left_q, left_d;
	logic signed [17:0] pos_d;
	logic [17:0]       tgt_q, tgt_d;
	logic              step_ev;

	always_comb begin
		req_new = (~enable_source_mode & di2_is_resync & di2_s_q[1] & ~di2_old_q)
			| (enable_source_mode & rr_s_q[1] & ~rr_old_q)
			| algo_resync_req | (hrs_hit & ~hrs_old_q);
	end

	// target in steps: min + (max-min) * pct * limit / 10000
	logic [7:0]  pct_sel;
	logic [31:0] span_prod;
	logic [17:0] tgt_steps;
	always_comb begin
		pct_sel   = (st_q == evp_pkg::EVP_ST_TO_STBY) ? standby_position : target_pct;
		span_prod = 32'((vp.max_steps - vp.min_steps) * pct_sel * opening_limit_pct);
		tgt_steps = 18'(vp.min_steps) + 18'(span_prod / 32'h0000_2710);
	end

	always_comb begin
		st_d   = st_q;
		pend_d = resync_pending_q | req_new;
		left_d = left_q;
		pos_d  = position_q;
		tgt_d  = tgt_q;
		case (st_q)
			evp_pkg::EVP_ST_POWERUP: begin
				st_d   = evp_pkg::EVP_ST_RESYNC;
				left_d = 17'(vp.over_steps);
			end
			evp_pkg::EVP_ST_RESYNC: begin
				if (step_ev && left_q != 17'h0_0000) begin
					left_d = left_q - 17'h0_0001;
				end else if (left_q == 17'h0_0000) begin
					pos_d  = $signed(18'(vp.min_steps));
					pend_d = req_new;
					st_d   = evp_pkg::EVP_ST_STBY_OFF;
				end
			end
			evp_pkg::EVP_ST_STBY_OFF: begin
				if (resync_pending_q) begin
					st_d   = evp_pkg::EVP_ST_RESYNC;
					left_d = 17'(position_q < 0 ? 18'h0_0000 : 18'(position_q))
						+ 17'(32'(vp.max_steps) * 32'h0000_000A / 32'h0000_0064);
				end else if (valve_enable && !cfg_error) begin
					st_d = evp_pkg::EVP_ST_ENABLED;
				end
			end
			evp_pkg::EVP_ST_ENABLED, evp_pkg::EVP_ST_FORCED: begin
				st_d  = forced_move ? evp_pkg::EVP_ST_FORCED : evp_pkg::EVP_ST_ENABLED;
				tgt_d = tgt_steps;
				if (!valve_enable) begin
					st_d = evp_pkg::EVP_ST_TO_STBY;
				end
			end
			evp_pkg::EVP_ST_TO_STBY: begin
				tgt_d = tgt_steps;
				// tgt_q still holds the enabled target on the first cycle here
				if ($signed(tgt_q) == position_q && $signed(tgt_steps) == position_q
					&& !step_ev) begin
					st_d = evp_pkg::EVP_ST_STBY_OFF;
				end
			end
			default: st_d = evp_pkg::EVP_ST_POWERUP;
		endcase
		if (st_q != evp_pkg::EVP_ST_RESYNC && step_ev) begin
			pos_d = step_dir_open ? position_q + 18'sh0_0001 : position_q - 18'sh0_0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_q <= evp_pkg::EVP_ST_POWERUP;
			resync_pending_q <= 1'b0;
			left_q <= 17'h0_0000;
			position_q <= 18'sh0_0000;
			tgt_q <= 18'h0_0000;
			di2_s_q <= 2'b00;
			rr_s_q <= 2'b00;
			di2_old_q <= 1'b0;
			rr_old_q <= 1'b0;
			hrs_old_q <= 1'b0;
		end else begin
			st_q <= st_d;
			resync_pending_q <= pend_d;
			left_q <= left_d;
			position_q <= pos_d;
			tgt_q <= tgt_d;
			di2_s_q <= di2_s_d;
			rr_s_q <= rr_s_d;
			di2_old_q <= di2_s_q[1];
			rr_old_q <= rr_s_q[1];
			hrs_old_q <= hrs_hit;
		end
	end

	assign resync_busy = (st_q == evp_pkg::EVP_ST_RESYNC);
	assign state_code  = st_q;

	// step rate selection and prescaler
	logic [15:0] rate;
	logic [31:0] per_cyc, pre_q, pre_d;
	logic        moving, dc_hold;
	always_comb begin
		rate = vp.rate_sps;
		if (op_mode == evp_pkg::EVP_MODE_DEBUG && debug_step_rate != 16'h0000 &&
			debug_step_rate < vp.rate_sps) begin
			rate = debug_step_rate;
		end
		if (resync_busy && left_q < 17'(`EVP_DECEL_STEPS)) begin
			rate = vp.rate_sps >> 1;
		end
		if (rate == 16'h0000) begin
			rate = 16'h0001;
		end
		per_cyc = `EVP_CLK_HZ / 32'(rate);
	end
	assign moving = resync_busy ? (left_q != 17'h0_0000) : ($signed(tgt_q) != position_q &&
		(st_q == evp_pkg::EVP_ST_ENABLED || st_q == evp_pkg::EVP_ST_FORCED ||
		st_q == evp_pkg::EVP_ST_TO_STBY));
	always_comb begin
		pre_d = (pre_q >= per_cyc - 32'h0000_0001) ? 32'h0000_0000 : pre_q + 32'h0000_0001;
		step_ev = moving && !dc_hold && (pre_q >= per_cyc - 32'h0000_0001);
	end
	assign step_pulse    = step_ev;
	assign step_dir_open = !resync_busy && ($signed(tgt_q) > position_q);

	// duty limiting over a 100 ms frame
	logic [15:0] ms_q, ms_d;
	logic [7:0]  fr_q, fr_d;
	logic        forced;
	assign forced = resync_busy || st_q == evp_pkg::EVP_ST_FORCED;
	always_comb begin
		ms_d = (ms_q == 16'(`EVP_CYC_PER_MS - 32'h1)) ? 16'h0000 : ms_q + 16'h0001;
		fr_d = fr_q;
		if (ms_q == 16'(`EVP_CYC_PER_MS - 32'h1)) begin
			fr_d = (fr_q == `EVP_DUTY_PERIOD_MS - 8'h01) ? 8'h00 : fr_q + 8'h01;
		end
		dc_hold = !forced && valve_duty_limit < `EVP_DUTY_FULL_PCT
			&& fr_q >= valve_duty_limit;
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pre_q <= 32'h0000_0000;
			ms_q  <= 16'h0000;
			fr_q  <= 8'h00;
			microsteps_q <= `EVP_MICRO_SLOW;
			position_pct_q <= 8'h00;
			setpoint_pct_q <= 8'h00;
		end else begin
			pre_q <= moving ? pre_d : 32'h0000_0000;
			ms_q  <= ms_d;
			fr_q  <= fr_d;
			microsteps_q <= (driving_mode_select != 8'h00) ? driving_mode_select :
				((vp.rate_sps > `EVP_AUTO_RATE_SPS) ? `EVP_MICRO_FAST : `EVP_MICRO_SLOW);
			position_pct_q <= (vp.max_steps > vp.min_steps && position_q > $signed(18'(vp.min_steps))
				&& opening_limit_pct != 8'h00)
				? 8'(32'(18'(position_q) - 18'(vp.min_steps)) * 32'h0000_2710 /
				(32'(vp.max_steps - vp.min_steps) * 32'(opening_limit_pct))) : 8'h00;
			setpoint_pct_q <= target_pct;
		end
	end
	assign use_op_current  = !dc_hold;
	assign coil_current_ma = dc_hold ? vp.hold_ma : vp.op_ma;

	// assertions
	duty_full_off_a: assert property (@(posedge mclk) disable iff (!nrst)
		valve_duty_limit >= `EVP_DUTY_FULL_PCT |-> use_op_current) else $error("duty not off");
	forced_cont_a: assert property (@(posedge mclk) disable iff (!nrst)
		resync_busy || st_q == evp_pkg::EVP_ST_FORCED |-> use_op_current)
		else $error("forced move limited");
	auto_micro_a: assert property (@(posedge mclk) disable iff (!nrst)
		driving_mode_select == 8'h00 && $stable(vp.rate_sps) && vp.rate_sps > `EVP_AUTO_RATE_SPS
		|=> microsteps_q == `EVP_MICRO_FAST) else $error("auto micro wrong");
	cfg_err_a: assert property (@(posedge mclk) disable iff (!nrst)
		vp.max_steps == 16'h0000 |-> cfg_error_code == 8'h17) else $error("no cfg error");
	pend_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		resync_pending_q && !resync_busy |=> resync_pending_q)
		else $error("request lost");
	resync_stby_a: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(resync_busy) |-> $past(st_q) == evp_pkg::EVP_ST_STBY_OFF
		|| $past(st_q) == evp_pkg::EVP_ST_POWERUP) else $error("resync outside stby");
	step_space_a: assert property (@(posedge mclk) disable iff (!nrst)
		step_pulse |=> !step_pulse) else $error("steps too close");
	pos_set_a: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(resync_busy) |-> position_q == $signed(18'($past(vp.min_steps))))
		else $error("position not reset");
	stby_reach_a: assert property (@(posedge mclk) disable iff (!nrst)
		st_q == evp_pkg::EVP_ST_TO_STBY ##1 st_q == evp_pkg::EVP_ST_STBY_OFF
		|-> $past(position_q) == $signed($past(tgt_steps)))
		else $error("stand-by target missed");
	resync_c: cover property (@(posedge mclk) disable iff (!nrst) $fell(resync_busy));
	enable_c: cover property (@(posedge mclk) disable iff (!nrst) st_q == evp_pkg::EVP_ST_ENABLED);
	hold_c: cover property (@(posedge mclk) disable iff (!nrst) dc_hold);
	forced_c: cover property (@(posedge mclk) disable iff (!nrst) st_q == evp_pkg::EVP_ST_FORCED);
	debug_c: cover property (@(posedge mclk) disable iff (!nrst)
		op_mode == evp_pkg::EVP_MODE_DEBUG && step_pulse);
endmodule

// ---- test/evp_coil_model.sv ----
`timescale 1ns/10ps
// coil side: tallies steps each way and the shortest step spacing seen
module evp_coil_model (
	input wire logic mclk,
	input wire logic step_pulse,
	input wire logic step_dir_open
);
	int n_open = 0;
	int n_close = 0;
	int gap = 0;
	int min_gap = 32'h7FFF_FFFF;
	// a coil cannot refuse a step, so nothing flows back to the block
	always @(posedge mclk) begin
		gap++;
		if (step_pulse === 1'b1) begin
			if (step_dir_open === 1'b1)
				n_open++;
			else
				n_close++;
			if (gap < min_gap)
				min_gap = gap;
			gap = 0;
		end
	end
endmodule

// ---- test/evp_positioner_test.sv ----
`timescale 1ns/10ps
module evp_positioner_test;
	logic               mclk, nrst;
	logic [7:0]         valve_model_select, gen_step_mode, driving_mode_select;
	logic [7:0]         valve_duty_limit, opening_limit_pct, standby_position, target_pct;
	logic [15:0]        gen_min_steps, gen_max_steps, gen_over_steps, gen_rate_sps;
	logic [15:0]        gen_op_ma, gen_hold_ma, debug_step_rate;
	logic               enable_source_mode, di2_is_resync, digital_input_two;
	logic               resync_request_flag, algo_resync_req, valve_enable, forced_move;
	logic [31:0]        operating_hours_count, resync_interval_hours;
	logic [1:0]         op_mode;
	logic               step_pulse, step_dir_open, use_op_current, resync_pending_q;
	logic               resync_busy, cfg_error;
	logic [15:0]        coil_current_ma;
	logic [7:0]         microsteps_q, position_pct_q, setpoint_pct_q, cfg_error_code;
	logic signed [17:0] position_q;
	logic [2:0]         state_code;
	int                 err_total = 0;
	int                 samples_checked = 0;

	evp_positioner dut (.*);
	evp_coil_model coil (.mclk(mclk), .step_pulse(step_pulse), .step_dir_open(step_dir_open));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic finish_test;
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic wait_st(logic [2:0] s, int lim);
		int i;
		for (i = 0; i < lim && state_code !== s; i++)
			@(negedge mclk);
		chk("state_code", 32'(s), 32'(state_code));
	endtask

	task automatic clr;
		coil.n_open = 0;
		coil.n_close = 0;
		coil.min_gap = 32'h7FFF_FFFF;
	endtask

	// closing run through resync back to stand-by off; gmin is the shortest allowed spacing
	task automatic resync_done(int n_exp, int gmin);
		wait_st(evp_pkg::EVP_ST_RESYNC, 30000);
		wait_st(evp_pkg::EVP_ST_STBY_OFF, 30000);
		chk("close_steps", n_exp, coil.n_close);
		chk("open_steps", 0, coil.n_open);
		chk("position_q", 0, position_q);
		chk("spacing_ok", 1, coil.min_gap >= gmin);
		chk("resync_pending_q", 0, resync_pending_q);
	endtask

	task automatic t_micro;
		gen_rate_sps = 16'h0272;
		cyc(8);
		chk("microsteps_q", 8'h08, microsteps_q);
		gen_rate_sps = 16'h0270;
		cyc(8);
		chk("microsteps_q", 8'h10, microsteps_q);
		driving_mode_select = 8'h04;
		cyc(8);
		chk("microsteps_q", 8'h04, microsteps_q);
		driving_mode_select = 8'h00;
		gen_rate_sps = 16'h4E20;
		cyc(8);
		chk("microsteps_q", 8'h08, microsteps_q);
	endtask

	// enable must be refused while the configuration is invalid
	task automatic t_cfg;
		gen_max_steps = 16'h0000;
		valve_enable = 1'b1;
		cyc(8);
		chk("cfg_error", 1, cfg_error);
		chk("cfg_error_code", 8'h17, cfg_error_code);
		chk("state_code", 32'(evp_pkg::EVP_ST_STBY_OFF), 32'(state_code));
		valve_enable = 1'b0;
		gen_max_steps = 16'h0014;
		cyc(8);
		chk("cfg_error", 0, cfg_error);
		valve_model_select = 8'h14;
		cyc(8);
		chk("coil_current_ma", 16'h00C8, coil_current_ma);
		chk("microsteps_q", 8'h10, microsteps_q);
		valve_model_select = 8'h01;
		cyc(8);
		chk("cfg_error", 1, cfg_error);
		valve_model_select = 8'h00;
		cyc(8);
		chk("coil_current_ma", 16'h0064, coil_current_ma);
	endtask

	// half of a half-limited range: 25 percent of 20 steps
	task automatic t_move;
		int i;
		int bad;
		bad = 0;
		clr();
		opening_limit_pct = 8'h32;
		target_pct = 8'h32;
		valve_enable = 1'b1;
		for (i = 0; i < 20000 && position_q !== 18'sh0_0005; i++) begin
			@(negedge mclk);
			if (step_pulse === 1'b1 && use_op_current !== 1'b1)
				bad++;
		end
		chk("open_steps", 5, coil.n_open);
		chk("held_steps", 0, bad);
		chk("step_gap", 1000, coil.min_gap);
		// debug rate is half the valve rate; target 100 percent of a 50 percent limit
		clr();
		op_mode = 2'h2;
		debug_step_rate = 16'h2710;
		target_pct = 8'h64;
		for (i = 0; i < 20000 && position_q !== 18'sh0_000A; i++)
			@(negedge mclk);
		chk("open_steps", 5, coil.n_open);
		chk("step_gap", 2000, coil.min_gap);
		op_mode = 2'h0;
		cyc(2);
		chk("position_pct_q", 8'h64, position_pct_q);
		chk("setpoint_pct_q", 8'h64, setpoint_pct_q);
		chk("position_q", 10, position_q);
		// more than 1 ms has run since reset, so a 1 percent limit is past its share
		valve_duty_limit = 8'h01;
		cyc(2);
		chk("use_op_current", 0, use_op_current);
		chk("coil_current_ma", 16'h0032, coil_current_ma);
		forced_move = 1'b1;
		cyc(2);
		chk("use_op_current", 1, use_op_current);
		forced_move = 1'b0;
		valve_duty_limit = 8'h64;
		cyc(2);
		chk("use_op_current", 1, use_op_current);
		chk("coil_current_ma", 16'h0064, coil_current_ma);
		algo_resync_req = 1'b1;
		cyc(1);
		algo_resync_req = 1'b0;
		cyc(20);
		chk("resync_pending_q", 1, resync_pending_q);
		chk("state_code", 32'(evp_pkg::EVP_ST_ENABLED), 32'(state_code));
		clr();
		valve_enable = 1'b0;
		resync_done(12, 1000);
	endtask

	task automatic t_sources;
		int k;
		for (k = 0; k < 3; k++) begin
			clr();
			enable_source_mode = (k == 1);
			digital_input_two = (k == 0);
			resync_request_flag = (k == 1);
			operating_hours_count = (k == 2) ? 32'h0000_0010 : 32'h0000_0000;
			cyc(6);
			digital_input_two = 1'b0;
			resync_request_flag = 1'b0;
			resync_done(2, 2000);
		end
	endtask

	initial begin
		nrst = 1'b0;
		valve_model_select = 8'h00;
		gen_min_steps = 16'h0000;
		gen_max_steps = 16'h0014;
		gen_over_steps = 16'h0004;
		gen_rate_sps = 16'h4E20;
		gen_op_ma = 16'h0064;
		gen_hold_ma = 16'h0032;
		gen_step_mode = 8'h00;
		driving_mode_select = 8'h00;
		valve_duty_limit = 8'h64;
		enable_source_mode = 1'b0;
		di2_is_resync = 1'b1;
		digital_input_two = 1'b0;
		resync_request_flag = 1'b0;
		algo_resync_req = 1'b0;
		operating_hours_count = 32'h0000_0000;
		resync_interval_hours = 32'h0000_0010;
		valve_enable = 1'b0;
		forced_move = 1'b0;
		op_mode = 2'h0;
		debug_step_rate = 16'h0000;
		opening_limit_pct = 8'h64;
		standby_position = 8'h00;
		target_pct = 8'h00;
		cyc(2);
		nrst = 1'b1;
		resync_done(4, 2000);
		t_micro();
		t_cfg();
		t_move();
		t_sources();
		finish_test();
	end

	// whole plan needs about 50k cycles; allow well beyond that
	initial begin
		#(100000 * 50);
		err_total++;
		finish_test();
	end
endmodule
